// *** core/wvrf_lane_merge.sv ***
// per-element merge of a result into the old register contents
// assumes the caller supplies old contents, mask and vector length of one write
`timescale 1ns/1ps
module wvrf_lane_merge #(
  parameter int EW = wvrf_pkg::ELEM_W
) (
  input  wire logic [wvrf_pkg::VLEN-1:0] old_val,
  input  wire logic [wvrf_pkg::VLEN-1:0] new_val,
  input  wire logic [wvrf_pkg::KW-1:0]   mask,
  input  wire logic                      use_mask,
  input  wire logic                      zeroing,
  input  wire logic [1:0]                vl,
  input  wire logic                      legacy,
  output logic      [wvrf_pkg::VLEN-1:0] merged
);
  localparam int NE = wvrf_pkg::VLEN / EW;
  always_comb begin
    int width;
    width  = wvrf_pkg::vl_bits(vl);
    merged = '0;
    for (int e = 0; e < NE; e++) begin
      if (legacy) begin
        // old 128-bit set never touches the upper part
        merged[e*EW +: EW] = (e * EW < wvrf_pkg::LEG_W) ? new_val[e*EW +: EW]
                                                        : old_val[e*EW +: EW]; // see RULE19
      end else if (e * EW >= width) begin
        merged[e*EW +: EW] = '0; // see RULE10
      end else if (!use_mask || mask[e]) begin
        merged[e*EW +: EW] = new_val[e*EW +: EW]; // see RULE21
      end else if (zeroing) begin
        merged[e*EW +: EW] = '0; // see RULE9
      end else begin
        merged[e*EW +: EW] = old_val[e*EW +: EW]; // see RULE9
      end
    end
  end
endmodule

// *** core/wvrf_top.sv ***
// wide vector register file with mask registers, fault checks and feature query
// assumes the decode pipeline drives the issue, read and mask ports on clk_sys
// and software reaches the control words over avalon-mm
//
// Operation
// RULE1: emulation control bit never traps prefixed vector instructions.
// RULE2: state enable bits 2:1 both zero make prefixed vector ops fault undefined.
// RULE3: control word bit 10 announces the simd float fault handler.
// RULE4: 32 vector registers in 64-bit mode, only 8 in 32-bit mode.
// RULE5: 256-bit and 128-bit registers alias the low part of 512-bit storage.
// RULE6: eight mask registers of 64 bits each.
// RULE7: only mask registers one to seven predicate element writes.
// RULE8: mask select zero updates every destination element unconditionally.
// RULE9: masked element is zeroed when zeroing bit set, else merged.
// RULE10: 128 or 256-bit prefixed results clear destination bits above them.
// RULE11: extended prefix on legacy integer or float stack registers faults.
// RULE12: mandatory prefix and escape bytes come from compacted prefix fields.
// RULE13: broadcast replicates the memory element across all second operand lanes.
// RULE14: all-register float ops use embedded rounding over the global control.
// RULE15: mask instructions touch only mask and general registers, never vectors.
// RULE16: feature leaf 07h subleaf 0 reports base wide vector in ebx bit 16.
// RULE17: feature leaf 1 reports ecx bit 27 when state read enabled.
// RULE18: software checks state enable bits 7:5 and 2:1 before wide use.
// RULE19: unprefixed 128-bit instructions leave bits 255:128 untouched.
// RULE20: unmasked float exception with handler flag clear faults undefined.
// RULE21: mask bit i governs destination element i.
`timescale 1ns/1ps
module wvrf_top #(
  parameter logic FEAT_WIDE = 1'b1
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic [2:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire logic                      iss_valid,
  input  wire logic [1:0]                iss_cls,
  input  wire logic                      iss_legacy_regs,
  input  wire logic                      iss_wr,
  input  wire logic [4:0]                iss_dst,
  input  wire logic [1:0]                iss_vl,
  input  wire logic [2:0]                iss_kidx,
  input  wire logic                      iss_zero,
  input  wire logic [1:0]                iss_pp,
  input  wire logic [1:0]                iss_mm,
  input  wire logic                      iss_fp_exc,
  input  wire logic                      iss_all_reg,
  input  wire logic                      iss_rc_en,
  input  wire logic [1:0]                iss_rc,
  input  wire logic [1:0]                global_rc,
  input  wire logic [wvrf_pkg::VLEN-1:0] iss_data,
  output logic                           undefined_opcode_fault,
  output logic                           simd_float_fault,
  output logic                           emu_trap,
  output logic [7:0]                     dec_prefix,
  output logic [15:0]                    dec_escape,
  output logic [1:0]                     eff_rc,
  input  wire logic [4:0]                rd_a_idx,
  input  wire logic [4:0]                rd_b_idx,
  input  wire logic                      rd_bcast,
  input  wire logic [wvrf_pkg::ELEM_W-1:0] rd_mem_elem,
  output logic [wvrf_pkg::VLEN-1:0]      rd_a_data,
  output logic [wvrf_pkg::VLEN-1:0]      rd_b_data,
  input  wire logic                      kwr_valid,
  input  wire logic [2:0]                kwr_idx,
  input  wire logic [wvrf_pkg::KW-1:0]   kwr_data,
  input  wire logic [2:0]                krd_idx,
  output logic [wvrf_pkg::KW-1:0]        krd_data,
  input  wire logic                      fq_valid,
  input  wire logic [31:0]               fq_leaf,
  input  wire logic [31:0]               fq_sub,
  output logic                           fq_done,
  output logic [31:0]                    fq_ebx,
  output logic [31:0]                    fq_ecx
);
  //////////////////////////////////////////////////////////////////////////////
  logic [wvrf_pkg::VLEN-1:0] vreg_q [wvrf_pkg::NVREG];
  logic [wvrf_pkg::KW-1:0]   kreg_q [wvrf_pkg::NKREG];
  logic [31:0]               sys_q;
  logic [31:0]               cr4_q;
  logic [31:0]               xse_q;
  logic [2:0]                last_fault_q;
  logic [15:0]               fault_cnt_q;
  logic                      ack_q;
  logic                      ud_d;
  logic                      xm_d;
  logic                      emu_d;
  logic                      wr_ok;
  wvrf_pkg::wvrf_fault_t     cause_d;
  logic [wvrf_pkg::VLEN-1:0] merged;
  logic [wvrf_pkg::VLEN-1:0] old_dst;
  logic [4:0]                dst_eff;
  logic                      mode64;
  logic                      xstate_off;

  // 32-bit mode sees only the low eight registers
  function automatic logic idx_ok(input logic [4:0] idx, input logic m64);
    return m64 || (idx < 5'(wvrf_pkg::NVREG32)); // see RULE4
  endfunction

  function automatic logic [7:0] pp_byte(input logic [1:0] pp);
    case (pp)
      2'h1:    return wvrf_pkg::PFX_66;
      2'h2:    return wvrf_pkg::PFX_F3;
      2'h3:    return wvrf_pkg::PFX_F2;
      default: return wvrf_pkg::PFX_NONE;
    endcase
  endfunction

  function automatic logic [15:0] mm_esc(input logic [1:0] mm);
    case (mm)
      2'h1:    return wvrf_pkg::ESC_0F;
      2'h2:    return wvrf_pkg::ESC_0F38;
      2'h3:    return wvrf_pkg::ESC_0F3A;
      default: return wvrf_pkg::ESC_NONE;
    endcase
  endfunction

  assign mode64     = sys_q[wvrf_pkg::SYS_M64];
  assign xstate_off = (xse_q[wvrf_pkg::XSE_HI:wvrf_pkg::XSE_LO] == 2'h0);
  assign dst_eff    = mode64 ? iss_dst : {2'h0, iss_dst[2:0]};
  assign old_dst    = vreg_q[dst_eff];

  //////////////////////////////////////////////////////////////////////////////
  // fault decision; one fault at most per issued instruction
  always_comb begin
    ud_d    = 1'b0;
    xm_d    = 1'b0;
    emu_d   = 1'b0;
    cause_d = wvrf_pkg::WVRF_F_NONE;
    if (iss_valid) begin
      if (iss_cls != wvrf_pkg::WVRF_CLS_LEGACY && xstate_off) begin
        ud_d    = 1'b1; // see RULE2
        cause_d = wvrf_pkg::WVRF_F_XSTATE;
      end else if (iss_cls == wvrf_pkg::WVRF_CLS_EXT && iss_legacy_regs) begin
        ud_d    = 1'b1; // see RULE11
        cause_d = wvrf_pkg::WVRF_F_LEGREG;
      end else if (!idx_ok(iss_dst, mode64)) begin
        ud_d    = 1'b1; // see RULE4
        cause_d = wvrf_pkg::WVRF_F_INDEX;
      end else if (iss_cls == wvrf_pkg::WVRF_CLS_EXT && iss_mm == 2'h0) begin
        // reserved escape code in the compacted field
        ud_d    = 1'b1; // see RULE12
        cause_d = wvrf_pkg::WVRF_F_ESC;
      end else if (iss_cls == wvrf_pkg::WVRF_CLS_LEGACY && sys_q[wvrf_pkg::SYS_EMU]) begin
        // only the old set is emulated this way
        emu_d   = 1'b1; // see RULE1
        cause_d = wvrf_pkg::WVRF_F_EMU;
      end else if (iss_fp_exc && !cr4_q[wvrf_pkg::CR4_OSF]) begin
        ud_d    = 1'b1; // see RULE20
        cause_d = wvrf_pkg::WVRF_F_FPUD;
      end else if (iss_fp_exc) begin
        xm_d    = 1'b1; // see RULE3
        cause_d = wvrf_pkg::WVRF_F_FPXM;
      end
    end
  end

  assign wr_ok = iss_valid && iss_wr && !ud_d && !xm_d && !emu_d;

  wvrf_lane_merge #(
    .EW (wvrf_pkg::ELEM_W)
  ) u_merge (
    .old_val  (old_dst),
    .new_val  (iss_data),
    .mask     (kreg_q[iss_kidx]),
    // mask zero selects no predicate at all
    .use_mask (iss_cls == wvrf_pkg::WVRF_CLS_EXT && iss_kidx != 3'h0), // see RULE7 see RULE8
    .zeroing  (iss_zero),
    .vl       (iss_cls == wvrf_pkg::WVRF_CLS_LEGACY ? wvrf_pkg::VL_128 : iss_vl),
    .legacy   (iss_cls == wvrf_pkg::WVRF_CLS_LEGACY),
    .merged   (merged)
  );

  //////////////////////////////////////////////////////////////////////////////
  // one storage per register; narrower views are low slices of it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < wvrf_pkg::NVREG; i++) begin
        vreg_q[i] <= '0;
      end
    end else if (wr_ok) begin
      vreg_q[dst_eff] <= merged; // see RULE5
    end
  end

  // mask instructions write only here, never the vector storage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < wvrf_pkg::NKREG; i++) begin
        kreg_q[i] <= '0; // see RULE6
      end
    end else if (kwr_valid) begin
      kreg_q[kwr_idx] <= kwr_data; // see RULE15
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
      krd_data  <= '0;
    end else begin
      rd_a_data <= vreg_q[mode64 ? rd_a_idx : {2'h0, rd_a_idx[2:0]}];
      rd_b_data <= rd_bcast ? {wvrf_pkg::NELEM{rd_mem_elem}} // see RULE13
                            : vreg_q[mode64 ? rd_b_idx : {2'h0, rd_b_idx[2:0]}];
      krd_data  <= kreg_q[krd_idx];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      undefined_opcode_fault <= 1'b0;
      simd_float_fault       <= 1'b0;
      emu_trap               <= 1'b0;
      dec_prefix             <= wvrf_pkg::PFX_NONE;
      dec_escape             <= wvrf_pkg::ESC_NONE;
      eff_rc                 <= 2'h0;
    end else begin
      undefined_opcode_fault <= ud_d;
      simd_float_fault       <= xm_d;
      emu_trap               <= emu_d;
      if (iss_valid && iss_cls != wvrf_pkg::WVRF_CLS_LEGACY) begin
        dec_prefix <= pp_byte(iss_pp); // see RULE12
        dec_escape <= mm_esc(iss_mm); // see RULE12
      end
      if (iss_valid) begin
        eff_rc <= (iss_cls == wvrf_pkg::WVRF_CLS_EXT && iss_rc_en && iss_all_reg)
                  ? iss_rc : global_rc; // see RULE14
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // feature query answers one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fq_done <= 1'b0;
      fq_ebx  <= '0;
      fq_ecx  <= '0;
    end else begin
      fq_done <= fq_valid;
      if (fq_valid) begin
        fq_ebx <= '0;
        fq_ecx <= '0;
        if (fq_leaf == wvrf_pkg::LEAF_EXT && fq_sub == wvrf_pkg::SUB_ZERO) begin
          fq_ebx[wvrf_pkg::EBX_BASE] <= FEAT_WIDE; // see RULE16
        end
        if (fq_leaf == wvrf_pkg::LEAF_BASE) begin
          fq_ecx[wvrf_pkg::ECX_OSS] <= sys_q[wvrf_pkg::SYS_OSS]; // see RULE17
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon slave: every access sees exactly one wait cycle
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // software must enable bits 7:5 and 2:1 before wide use; kept as written
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sys_q <= wvrf_pkg::RST_WORD;
      cr4_q <= wvrf_pkg::RST_WORD;
      xse_q <= wvrf_pkg::RST_WORD; // see RULE18
    end else if (avs_write && ack_q) begin
      case (avs_address)
        wvrf_pkg::OFS_SYS: sys_q <= avs_writedata;
        wvrf_pkg::OFS_CR4: cr4_q <= avs_writedata; // see RULE3
        wvrf_pkg::OFS_XSE: xse_q <= avs_writedata;
        default:           sys_q <= sys_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_q) begin
      case (avs_address)
        wvrf_pkg::OFS_SYS:  avs_readdata <= sys_q;
        wvrf_pkg::OFS_CR4:  avs_readdata <= cr4_q;
        wvrf_pkg::OFS_XSE:  avs_readdata <= xse_q;
        wvrf_pkg::OFS_STAT: avs_readdata <= {13'h0, last_fault_q, fault_cnt_q};
        default:            avs_readdata <= '0;
      endcase
    end
  end

  // status shows the last fault cause and a wrapping fault count
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      last_fault_q <= 3'h0;
      fault_cnt_q  <= 16'h0;
    end else if (ud_d || xm_d || emu_d) begin
      last_fault_q <= cause_d;
      fault_cnt_q  <= fault_cnt_q + 16'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  localparam int LEG_HI = wvrf_pkg::LEG_W;
  logic [wvrf_pkg::VLEN-LEG_HI-1:0] old_up;
  assign old_up = old_dst[wvrf_pkg::VLEN-1:LEG_HI];

  chk_xstate_ud: assert property (iss_valid && iss_cls != wvrf_pkg::WVRF_CLS_LEGACY // see RULE2
    && xstate_off |=> undefined_opcode_fault && !emu_trap)
    else $error("vector op with state disabled did not fault");
  chk_emu_not_vec: assert property (iss_valid && iss_cls != wvrf_pkg::WVRF_CLS_LEGACY // see RULE1
    |=> !emu_trap)
    else $error("emulation trap on a prefixed op");
  chk_legreg_ud: assert property (iss_valid && iss_cls == wvrf_pkg::WVRF_CLS_EXT // see RULE11
    && iss_legacy_regs |=> undefined_opcode_fault)
    else $error("extended prefix on legacy registers accepted");
  chk_index_range: assert property (iss_valid && !mode64 && iss_dst >= 5'(wvrf_pkg::NVREG32) // see RULE4
    |=> undefined_opcode_fault)
    else $error("high register reached in 32-bit mode");
  chk_fp_conv: assert property (iss_valid && iss_fp_exc && !cr4_q[wvrf_pkg::CR4_OSF] // see RULE20
    |=> !simd_float_fault && (undefined_opcode_fault || emu_trap))
    else $error("float exception not turned into undefined fault");
  chk_k0_full: assert property (wr_ok && iss_cls == wvrf_pkg::WVRF_CLS_EXT // see RULE8
    && iss_kidx == 3'h0 && iss_vl == wvrf_pkg::VL_512 |=> vreg_q[$past(dst_eff)] == $past(iss_data))
    else $error("mask zero write was predicated");
  chk_upper_clear: assert property (wr_ok && iss_cls == wvrf_pkg::WVRF_CLS_VEC // see RULE10
    && iss_vl == wvrf_pkg::VL_128 |=> vreg_q[$past(dst_eff)][wvrf_pkg::VLEN-1:LEG_HI] == '0)
    else $error("upper bits not cleared");
  chk_legacy_keep: assert property (wr_ok && iss_cls == wvrf_pkg::WVRF_CLS_LEGACY // see RULE19
    |=> vreg_q[$past(dst_eff)][wvrf_pkg::VLEN-1:LEG_HI] == $past(old_up))
    else $error("legacy op changed upper bits");
  chk_zero_elem: assert property (wr_ok && iss_cls == wvrf_pkg::WVRF_CLS_EXT && iss_zero // see RULE9
    && iss_kidx != 3'h0 && !kreg_q[iss_kidx][1]
    |=> vreg_q[$past(dst_eff)][2*wvrf_pkg::ELEM_W-1:wvrf_pkg::ELEM_W] == '0)
    else $error("masked element not zeroed");
  chk_feat_bit: assert property (fq_valid && fq_leaf == wvrf_pkg::LEAF_EXT // see RULE16
    && fq_sub == wvrf_pkg::SUB_ZERO |=> fq_done && fq_ebx[wvrf_pkg::EBX_BASE] == FEAT_WIDE)
    else $error("base feature bit wrong");
  chk_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest)
    else $error("bus answer late");
  cov_masked_merge: cover property (wr_ok && iss_cls == wvrf_pkg::WVRF_CLS_EXT
    && iss_kidx != 3'h0 && !iss_zero);
  cov_bcast: cover property (rd_bcast ##1 rd_b_data != '0);
  cov_xm: cover property (simd_float_fault);
  cov_bus_write: cover property (avs_write && !avs_waitrequest);
endmodule

// *** inc/wvrf_pkg.sv ***
// constants, field positions and encodings of the wide vector register file
// assumes one 100 MHz core clock and a synchronous active-high reset
package wvrf_pkg;
  localparam int          VLEN      = 512;
  localparam int          NVREG     = 32;
  localparam int          NVREG32   = 8;
  localparam int          NKREG     = 8;
  localparam int          KW        = 64;
  localparam int          ELEM_W    = 32;
  localparam int          NELEM     = VLEN / ELEM_W;
  localparam int          LEG_W     = 128;
  localparam int          MID_W     = 256;
  localparam int          CLK_MHZ   = 100;
  // vector length field
  localparam logic [1:0]  VL_128    = 2'h0;
  localparam logic [1:0]  VL_256    = 2'h1;
  localparam logic [1:0]  VL_512    = 2'h2;
  // register word indices on the avalon slave
  localparam logic [2:0]  OFS_SYS   = 3'h0;
  localparam logic [2:0]  OFS_CR4   = 3'h1;
  localparam logic [2:0]  OFS_XSE   = 3'h2;
  localparam logic [2:0]  OFS_STAT  = 3'h3;
  localparam int          SYS_EMU   = 0;
  localparam int          SYS_M64   = 1;
  localparam int          SYS_OSS   = 2;
  localparam int          CR4_OSF   = 10;
  localparam int          XSE_LO    = 1;
  localparam int          XSE_HI    = 2;
  localparam logic [31:0] RST_WORD  = 32'h0;
  // feature query
  localparam logic [31:0] LEAF_BASE = 32'h1;
  localparam logic [31:0] LEAF_EXT  = 32'h7;
  localparam logic [31:0] SUB_ZERO  = 32'h0;
  localparam int          EBX_BASE  = 16;
  localparam int          ECX_OSS   = 27;
  // compacted prefix fields
  localparam logic [7:0]  PFX_NONE  = 8'h00;
  localparam logic [7:0]  PFX_66    = 8'h66;
  localparam logic [7:0]  PFX_F3    = 8'hf3;
  localparam logic [7:0]  PFX_F2    = 8'hf2;
  localparam logic [15:0] ESC_NONE  = 16'h0000;
  localparam logic [15:0] ESC_0F    = 16'h000f;
  localparam logic [15:0] ESC_0F38  = 16'h0f38;
  localparam logic [15:0] ESC_0F3A  = 16'h0f3a;
  typedef enum logic [1:0] {WVRF_CLS_LEGACY, WVRF_CLS_VEC, WVRF_CLS_EXT} wvrf_cls_t;
  typedef enum logic [2:0] {WVRF_F_NONE, WVRF_F_XSTATE, WVRF_F_LEGREG, WVRF_F_INDEX,
                            WVRF_F_ESC, WVRF_F_FPUD, WVRF_F_FPXM, WVRF_F_EMU} wvrf_fault_t;
  function automatic int vl_bits(input logic [1:0] vl);
    return (vl == VL_128) ? LEG_W : (vl == VL_256) ? MID_W : VLEN;
  endfunction
endpackage

// *** sim/wvrf_dec_model.sv ***
// decode pipeline model: one instruction per issue call on the issue port
// assumes clk_sys from the bench; fields change just after a rising edge
`timescale 1ns/1ps
module wvrf_dec_model (
  input  wire logic               clk_sys,
  output logic                    iss_valid,
  output logic [1:0]              iss_cls,
  output logic                    iss_legacy_regs,
  output logic                    iss_wr,
  output logic [4:0]              iss_dst,
  output logic [1:0]              iss_vl,
  output logic [2:0]              iss_kidx,
  output logic                    iss_zero,
  output logic [1:0]              iss_pp,
  output logic [1:0]              iss_mm,
  output logic                    iss_fp_exc,
  output logic                    iss_all_reg,
  output logic                    iss_rc_en,
  output logic [1:0]              iss_rc,
  output logic [wvrf_pkg::VLEN-1:0] iss_data
);
  initial begin
    {iss_valid, iss_cls, iss_dst, iss_vl, iss_kidx, iss_zero, iss_data} = '0;
    {iss_wr, iss_legacy_regs, iss_fp_exc, iss_all_reg, iss_rc_en, iss_rc, iss_pp, iss_mm} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // x packs {wr, legacy regs, fp exc, all reg, rc_en, rc, pp, mm}
  task automatic issue(input logic [1:0] c, input logic [4:0] dst, input logic [1:0] vl,
                       input logic [2:0] k, input logic z, input logic [10:0] x,
                       input logic [wvrf_pkg::VLEN-1:0] d);
    @(posedge clk_sys);
    {iss_valid, iss_cls, iss_dst, iss_vl, iss_kidx, iss_zero, iss_data} <= {1'b1, c, dst, vl, k, z, d};
    // compacted prefix and escape fields travel with the request
    {iss_wr, iss_legacy_regs, iss_fp_exc, iss_all_reg, iss_rc_en, iss_rc, iss_pp, iss_mm} <= x;
    @(posedge clk_sys);
    iss_valid <= 1'b0;
    // stale data is scrambled so a late sample cannot pass by luck
    iss_data <= ~d;
  endtask
endmodule

// *** sim/wvrf_top_tb.sv ***
// self-checking bench for the wide vector register file
// assumes wvrf_dec_model drives issue; bench drives bus, read, mask and query ports
`timescale 1ns/1ps
module wvrf_top_tb;
  localparam logic [10:0]  XW = 11'h401;
  localparam logic [511:0] ONES = {16{32'hffff_ffff}};
  localparam logic [511:0] PAT = {16{32'h1234_5678}};
  logic         clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [2:0]   avs_address = 3'h0, kwr_idx = 3'h0, krd_idx = 3'h0;
  logic [31:0]  avs_writedata = 32'h0, rd_mem_elem = 32'h0, fq_leaf = 32'h0, fq_sub = 32'h0;
  logic [4:0]   rd_a_idx = 5'h0, rd_b_idx = 5'h0;
  logic         rd_bcast = 1'b0, kwr_valid = 1'b0, fq_valid = 1'b0;
  logic [63:0]  kwr_data = 64'h0;
  logic [1:0]   global_rc = 2'h1;
  logic [31:0]  avs_readdata, fq_ebx, fq_ecx, q;
  logic         avs_waitrequest, undefined_opcode_fault, simd_float_fault, emu_trap, fq_done;
  logic [7:0]   dec_prefix;
  logic [15:0]  dec_escape;
  logic [1:0]   eff_rc, iss_cls, iss_vl, iss_pp, iss_mm, iss_rc;
  logic [4:0]   iss_dst;
  logic [2:0]   iss_kidx;
  logic         iss_valid, iss_legacy_regs, iss_wr, iss_zero, iss_fp_exc, iss_all_reg, iss_rc_en;
  logic [511:0] iss_data, rd_a_data, rd_b_data, shd;
  logic [63:0]  krd_data;
  logic [23:0]  dexp [4] = '{{wvrf_pkg::ESC_0F, wvrf_pkg::PFX_NONE}, {wvrf_pkg::ESC_0F,
                  wvrf_pkg::PFX_66}, {wvrf_pkg::ESC_0F38, wvrf_pkg::PFX_F3},
                  {wvrf_pkg::ESC_0F3A, wvrf_pkg::PFX_F2}};
  int           miscompares = 0;
  int           n_compared = 0;
  int           n;
  always #5 clk_sys = ~clk_sys;
  wvrf_dec_model u_dec (.clk_sys, .iss_valid, .iss_cls, .iss_legacy_regs, .iss_wr, .iss_dst,
    .iss_vl, .iss_kidx, .iss_zero, .iss_pp, .iss_mm, .iss_fp_exc, .iss_all_reg, .iss_rc_en,
    .iss_rc, .iss_data);
  wvrf_top dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .iss_valid, .iss_cls, .iss_legacy_regs, .iss_wr, .iss_dst,
    .iss_vl, .iss_kidx, .iss_zero, .iss_pp, .iss_mm, .iss_fp_exc, .iss_all_reg, .iss_rc_en,
    .iss_rc, .global_rc, .iss_data, .undefined_opcode_fault, .simd_float_fault, .emu_trap,
    .dec_prefix, .dec_escape, .eff_rc, .rd_a_idx, .rd_b_idx, .rd_bcast, .rd_mem_elem,
    .rd_a_data, .rd_b_data, .kwr_valid, .kwr_idx, .kwr_data, .krd_idx, .krd_data, .fq_valid,
    .fq_leaf, .fq_sub, .fq_done, .fq_ebx, .fq_ecx);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_v(input logic [511:0] got, input logic [511:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {avs_address, avs_writedata, avs_read, avs_write} <= {a, d, !w, w};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      close_out();
    end
    q = avs_readdata;
    {avs_read, avs_write} <= 2'h0;
  endtask
  task automatic ex(input logic [1:0] c, input logic [4:0] dst, input logic [1:0] vl,
                    input logic [2:0] k, input logic z, input logic [10:0] x,
                    input logic [511:0] d, input logic [2:0] f);
    u_dec.issue(c, dst, vl, k, z, x, d);
    #1 cmp_w({29'h0, undefined_opcode_fault, simd_float_fault, emu_trap}, {29'h0, f});
  endtask
  task automatic vchk(input logic [4:0] i, input logic [511:0] exp);
    @(posedge clk_sys);
    rd_a_idx <= i;
    @(posedge clk_sys);
    #1 cmp_v(rd_a_data, exp);
  endtask
  task automatic kw(input logic [2:0] i, input logic [63:0] d);
    @(posedge clk_sys);
    {kwr_valid, kwr_idx, kwr_data, krd_idx} <= {1'b1, i, d, i};
    @(posedge clk_sys);
    kwr_valid <= 1'b0;
    @(posedge clk_sys);
    #1 cmp_v({448'h0, krd_data}, {448'h0, d});
  endtask
  task automatic fq(input logic [31:0] lf, input logic [31:0] sb, input logic [63:0] e);
    @(posedge clk_sys);
    {fq_valid, fq_leaf, fq_sub} <= {1'b1, lf, sb};
    @(posedge clk_sys);
    fq_valid <= 1'b0;
    #1 cmp_v({447'h0, fq_done, fq_ebx, fq_ecx}, {447'h1, e});
  endtask
  // expected element merge, mask bit i governs 32-bit element i
  function automatic logic [511:0] mrg(input logic [511:0] o, input logic [511:0] d,
                                       input logic [63:0] m, input logic z);
    for (int i = 0; i < 16; i++) mrg[i*32+:32] = m[i] ? d[i*32+:32] : (z ? 32'h0 : o[i*32+:32]);
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    bus(1'b1, 3'h5, 32'hffff_ffff);
    bus(1'b0, 3'h5, 32'h0);
    cmp_w(q, 32'h0);
    ex(2'h2, 5'h3, wvrf_pkg::VL_512, 3'h0, 1'b0, XW, ONES, 3'h4);
    vchk(5'h3, 512'h0);
    bus(1'b1, wvrf_pkg::OFS_XSE, 32'he6);
    bus(1'b1, wvrf_pkg::OFS_SYS, 32'h7);
    fq(32'h1, 32'h0, 64'h0000_0000_0800_0000);
    fq(32'h7, 32'h0, 64'h0001_0000_0000_0000);
    fq(32'h7, 32'h1, 64'h0);
    ex(2'h1, 5'h3, wvrf_pkg::VL_512, 3'h0, 1'b0, XW, ONES, 3'h0);
    ex(2'h0, 5'h3, wvrf_pkg::VL_128, 3'h0, 1'b0, XW, 512'h0, 3'h1);
    bus(1'b1, wvrf_pkg::OFS_SYS, 32'h6);
    ex(2'h0, 5'h3, wvrf_pkg::VL_128, 3'h0, 1'b0, XW, 512'h0, 3'h0);
    vchk(5'h3, {ONES[511:128], 128'h0});
    for (int v = 1; v >= 0; v--) begin
      ex(2'h1, 5'h3, v[1:0], 3'h0, 1'b0, XW, ONES, 3'h0);
      vchk(5'h3, ONES >> (v == 1 ? 256 : 384));
    end
    kw(3'h1, 64'h5);
    shd = ONES >> 384;
    ex(2'h2, 5'h3, wvrf_pkg::VL_512, 3'h1, 1'b0, XW, ONES, 3'h0);
    shd = mrg(shd, ONES, 64'h5, 1'b0);
    vchk(5'h3, shd);
    ex(2'h2, 5'h3, wvrf_pkg::VL_512, 3'h1, 1'b1, XW, PAT, 3'h0);
    vchk(5'h3, mrg(shd, PAT, 64'h5, 1'b1));
    kw(3'h0, 64'h1);
    ex(2'h2, 5'h3, wvrf_pkg::VL_512, 3'h0, 1'b1, XW, ONES, 3'h0);
    vchk(5'h3, ONES);
    bus(1'b1, wvrf_pkg::OFS_SYS, 32'h4);
    ex(2'h2, 5'h9, wvrf_pkg::VL_512, 3'h0, 1'b0, XW, PAT, 3'h4);
    ex(2'h2, 5'h7, wvrf_pkg::VL_512, 3'h0, 1'b0, XW, PAT, 3'h0);
    vchk(5'h7, PAT);
    bus(1'b1, wvrf_pkg::OFS_SYS, 32'h6);
    ex(2'h2, 5'h14, wvrf_pkg::VL_512, 3'h0, 1'b0, XW, PAT, 3'h0);
    vchk(5'h14, PAT);
    ex(2'h2, 5'h5, wvrf_pkg::VL_512, 3'h0, 1'b0, 11'h601, PAT, 3'h4);
    ex(2'h2, 5'h0, wvrf_pkg::VL_512, 3'h0, 1'b0, 11'h101, 512'h0, 3'h4);
    bus(1'b1, wvrf_pkg::OFS_CR4, 32'h400);
    ex(2'h2, 5'h0, wvrf_pkg::VL_512, 3'h0, 1'b0, 11'h101, 512'h0, 3'h2);
    bus(1'b0, wvrf_pkg::OFS_CR4, 32'h0);
    cmp_w(q, 32'h400);
    ex(2'h2, 5'h0, wvrf_pkg::VL_512, 3'h0, 1'b0, 11'h000, 512'h0, 3'h4);
    for (int p = 0; p < 4; p++) begin
      ex(2'h2, 5'h0, wvrf_pkg::VL_512, 3'h0, 1'b0, {7'h0, p[1:0], p == 0 ? 2'h1 : p[1:0]},
         512'h0, 3'h0);
      cmp_w({8'h0, dec_escape, dec_prefix}, {8'h0, dexp[p]});
    end
    ex(2'h2, 5'h0, wvrf_pkg::VL_512, 3'h0, 1'b0, 11'h0e1, 512'h0, 3'h0);
    cmp_w({30'h0, eff_rc}, 32'h2);
    ex(2'h2, 5'h0, wvrf_pkg::VL_512, 3'h0, 1'b0, 11'h061, 512'h0, 3'h0);
    cmp_w({30'h0, eff_rc}, 32'h1);
    @(posedge clk_sys);
    {rd_b_idx, rd_mem_elem, rd_bcast} <= {5'h3, 32'hcafe_f00d, 1'b1};
    @(posedge clk_sys);
    rd_bcast <= 1'b0;
    #1 cmp_v(rd_b_data, {16{32'hcafe_f00d}});
    @(posedge clk_sys);
    #1 cmp_v(rd_b_data, ONES);
    close_out();
  end
endmodule
